// *** perf_sel_pkg.sv ***
package perf_sel_pkg;

	// ==================================================
	// Register map, byte addresses
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_COUNT = 4'h4;
	localparam logic [3:0] OFS_LAT = 4'h8;
	localparam logic [3:0] OFS_STATUS = 4'hC;

	// ==================================================
	// Field positions
	localparam int CTRL_EVT_LSB = 0;
	localparam int CTRL_MASK_LSB = 8;
	localparam int CTRL_EDGE_BIT = 16;
	localparam int CTRL_EN_BIT = 17;
	localparam int CTRL_INV_BIT = 18;
	localparam int CTRL_CMASK_LSB = 24;
	localparam int LAT_THR_LSB = 0;
	localparam int LAT_EN_BIT = 31;
	localparam int STAT_OVF_BIT = 0;
	localparam int STAT_EN_BIT = 1;
	localparam logic [31:0] CTRL_WMASK = 32'hFF07FFFF;
	localparam logic [31:0] LAT_WMASK = 32'h8000FFFF;

	// ==================================================
	// Reset values
	localparam logic [31:0] CTRL_RST = 32'h00000000;
	localparam logic [31:0] COUNT_RST = 32'h00000000;
	localparam logic [31:0] LAT_RST = 32'h00000000;

	// ==================================================
	// Event codes
	localparam logic [7:0] EV_MEM_RETIRED = 8'h0B;
	localparam logic [7:0] EV_STORE_XMISS = 8'h0C;
	localparam logic [7:0] EV_UOP_ISSUE = 8'h0E;
	localparam logic [7:0] EV_LOAD_SOURCE = 8'h0F;
	localparam logic [7:0] EV_FLOAT_OPS = 8'h10;
	localparam logic [7:0] EV_WIDE_INT = 8'h12;
	localparam logic [7:0] EV_LOAD_DISPATCH = 8'h13;
	localparam logic [7:0] EV_ARITH = 8'h14;
	localparam logic [7:0] EV_IQ_WRITES = 8'h17;
	localparam logic [7:0] EV_FIRST_DECODER = 8'h18;
	localparam logic [7:0] EV_DUAL_UOP = 8'h19;
	localparam logic [7:0] EV_IQ_CYCLES = 8'h1E;
	localparam logic [7:0] EV_LOOP_OVF = 8'h20;
	localparam logic [7:0] EV_L2_REQUEST = 8'h24;
	localparam logic [7:0] EV_L2_DATA = 8'h26;

	// Line state codes of a prefetch lookup
	localparam logic [1:0] LINE_I = 2'h0;
	localparam logic [1:0] LINE_S = 2'h1;

	localparam int RAW_W = 4;

	// ==================================================
	// Per-cycle strobes from pipeline and caches
	typedef struct packed {
		logic retired_load_instr;
		logic retired_store_instr;
		logic load_lat_valid;
		logic [15:0] load_lat;
		logic retired_store_xlate_miss;
		logic store_faulted;
		logic store_prefetch;
		logic [2:0] issued_uops;
		logic [2:0] fused_uops;
		logic [7:0] load_source;
		logic [7:0] float_class;
		logic [6:0] wide_int_class;
		logic [2:0] load_dispatch;
		logic divider_busy;
		logic multiply_ops;
		logic mul_in_dot_or_sad;
		logic [2:0] instr_queue_write_count;
		logic first_decoder_instrs;
		logic dual_microop_decodes;
		logic loop_stream_overflow;
		logic [7:0] l2_request;
		logic l2_load_rejected;
		logic [3:0] demand_state;
		logic pf_valid;
		logic pf_ownership;
		logic [1:0] pf_state;
	} event_in_t;

endpackage : perf_sel_pkg

// *** perf_count_qualifier.sv ***
`timescale 1ns/100ps
module perf_count_qualifier (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [perf_sel_pkg::RAW_W-1:0] raw,
	input wire logic [7:0] cmask,
	input wire logic invert,
	input wire logic edge_only,
	output logic [perf_sel_pkg::RAW_W-1:0] inc
);
	import perf_sel_pkg::*;

	typedef struct packed {
		logic prev;
	} qual_state_t;

	qual_state_t st;
	qual_state_t next_st;
	logic cond;

	// ==================================================
	// Threshold, invert and edge
	always_comb begin
		next_st = st;
		cond = ({4'h0, raw} >= cmask) ^ invert;
		inc = raw;
		if (cmask != 8'h00) begin
			if (edge_only) begin
				inc = {{(RAW_W-1){1'b0}}, cond & ~st.prev};
			end else begin
				inc = {{(RAW_W-1){1'b0}}, cond};
			end
		end
		next_st.prev = cond;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ==================================================
	// Checks
	sequence held_true_s;
		(cmask != 8'h00 && edge_only && cond) ##1
		(cmask != 8'h00 && edge_only && cond && $stable(cmask) && $stable(invert));
	endsequence

	thr_single_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmask != 8'h00) |-> (inc == {{(RAW_W-1){1'b0}}, cond}) || edge_only)
		else $error("threshold mode added more than the test result");
	edge_once_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		held_true_s |-> inc == '0)
		else $error("edge mode counted a held condition twice");
	raw_pass_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(cmask == 8'h00) |-> inc == raw)
		else $error("raw count not passed through");

endmodule : perf_count_qualifier

// *** perf_event_selector.sv ***
`timescale 1ns/100ps
// Summary of operation
// - Event 0B: mask 01 counts retired loads, mask 02 retired stores.
// - Event 0B mask 10 counts loads above latency threshold when enabled.
// - Event 0C mask 01 counts store translation misses, no prefetch or fault.
// - Event 0E mask 01 adds issued micro-ops; invert, threshold 1 counts idle.
// - Event 0E mask 02 adds fused micro-ops issued.
// - Event 0F: mask 02 sibling modified hit, 08 remote cache local home.
// - Event 0F: mask 10 remote home, 20 local memory, 80 uncacheable.
// - Event 10: masks 01 stack unit, 02 64-bit media, 04 SIMD float.
// - Event 10: masks 08 integer, 10 packed, 20 scalar, 40 single, 80 double.
// - Event 12: seven 128-bit integer classes, mask bits 01 to 40.
// - Event 13: load dispatch bypass, delayed, buffered; 07 counts all.
// - Event 14 mask 01 counts divider busy cycles; edge-invert counts divides.
// - Event 14 mask 02 counts multiplies, excluding dot-product and sum-abs-diff.
// - Event 17 adds queue writes per cycle; 1E counts cycles with writes.
// - Event 18 counts first-decoder instructions; 19 counts two-micro-op decodes.
// - Event 20 mask 01 counts loops that cannot stream from queue.
// - Event 24: load hits not rejected 01, misses 02, all loads 03.
// - Event 24: ownership-read hits 04, misses 08, write-combining included.
// - Event 24: fetch hits 10, misses 20, all fetches 30.
// - Event 24: prefetch hits 40, misses 80, all misses AA, everything FF.
// - Event 26: demand loads by state I, S, E, M; 0F all.
// - Event 26: prefetch I, S, E; ownership prefetch on shared counts as miss.
module perf_event_selector #(
	parameter int CNT_W = 32
) (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire perf_sel_pkg::event_in_t events,
	output logic [CNT_W-1:0] count_value
);
	import perf_sel_pkg::*;

	typedef struct packed {
		logic [31:0] ctrl;
		logic [CNT_W-1:0] count;
		logic [31:0] lat;
		logic overflow;
		logic ack;
		logic [31:0] rdata;
	} sel_state_t;

	sel_state_t st;
	sel_state_t next_st;

	logic [7:0] evsel;
	logic [7:0] umask;
	logic [7:0] cmask;
	logic enable;
	logic invert;
	logic edge_only;
	logic lat_over;
	logic [7:0] conds;
	logic [RAW_W-1:0] raw;
	logic [RAW_W-1:0] inc;
	logic [6:0] pf_onehot;
	logic req;
	logic take;
	logic [CNT_W:0] sum;

	// ==================================================
	// Helpers
	function automatic logic [RAW_W-1:0] popcount(input logic [7:0] v);
		logic [RAW_W-1:0] n;
		n = '0;
		for (int i = 0; i < 8; i++) begin
			n = n + {{(RAW_W-1){1'b0}}, v[i]};
		end
		return n;
	endfunction : popcount

	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] wr,
		input logic [3:0] be,
		input logic [31:0] wmask
	);
		logic [31:0] m;
		m = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				m[b*8 +: 8] = wr[b*8 +: 8];
			end
		end
		return m & wmask;
	endfunction : merge

	// ==================================================
	// Control fields
	assign evsel = st.ctrl[CTRL_EVT_LSB +: 8];
	assign umask = st.ctrl[CTRL_MASK_LSB +: 8];
	assign cmask = st.ctrl[CTRL_CMASK_LSB +: 8];
	assign enable = st.ctrl[CTRL_EN_BIT];
	assign invert = st.ctrl[CTRL_INV_BIT];
	assign edge_only = st.ctrl[CTRL_EDGE_BIT];
	assign count_value = st.count;

	// Facility must be armed, otherwise the class is meaningless
	assign lat_over = st.lat[LAT_EN_BIT] & events.load_lat_valid
		& events.retired_load_instr
		& (events.load_lat > st.lat[LAT_THR_LSB +: 16]);

	// ==================================================
	// Prefetch line state; ownership prefetch misses a shared line
	always_comb begin
		pf_onehot = '0;
		if (events.pf_valid) begin
			if (events.pf_ownership && events.pf_state == LINE_S) begin
				pf_onehot[4] = 1'b1;
			end else begin
				// Modified prefetch lines have no class bit here
				case (events.pf_state)
					LINE_I: pf_onehot[4] = 1'b1;
					LINE_S: pf_onehot[5] = 1'b1;
					2'h2: pf_onehot[6] = 1'b1;
					default: pf_onehot = '0;
				endcase
			end
		end
	end

	// ==================================================
	// Condition selection
	always_comb begin
		conds = '0;
		raw = '0;
		case (evsel)
			EV_MEM_RETIRED: begin
				conds[0] = events.retired_load_instr;
				conds[1] = events.retired_store_instr;
				conds[4] = lat_over;
				raw = popcount(conds & umask);
			end
			EV_STORE_XMISS: begin
				conds[0] = events.retired_store_xlate_miss & ~events.store_faulted
					& ~events.store_prefetch;
				raw = popcount(conds & umask);
			end
			EV_UOP_ISSUE: begin
				if (umask[0]) begin
					raw = raw + {1'b0, events.issued_uops};
				end
				if (umask[1]) begin
					raw = raw + {1'b0, events.fused_uops};
				end
			end
			EV_LOAD_SOURCE: begin
				conds[1] = events.load_source[1];
				conds[3] = events.load_source[3];
				conds[4] = events.load_source[4];
				conds[5] = events.load_source[5];
				conds[7] = events.load_source[7];
				raw = popcount(conds & umask);
			end
			EV_FLOAT_OPS: begin
				conds = events.float_class;
				raw = popcount(conds & umask);
			end
			EV_WIDE_INT: begin
				conds = {1'b0, events.wide_int_class};
				raw = popcount(conds & umask);
			end
			EV_LOAD_DISPATCH: begin
				conds = {5'h00, events.load_dispatch};
				raw = popcount(conds & umask);
			end
			EV_ARITH: begin
				conds[0] = events.divider_busy;
				conds[1] = events.multiply_ops & ~events.mul_in_dot_or_sad;
				raw = popcount(conds & umask);
			end
			EV_IQ_WRITES: begin
				if (umask[0]) begin
					raw = {1'b0, events.instr_queue_write_count};
				end
			end
			EV_IQ_CYCLES: begin
				conds[0] = events.instr_queue_write_count != 3'h0;
				raw = popcount(conds & umask);
			end
			EV_FIRST_DECODER: begin
				conds[0] = events.first_decoder_instrs;
				raw = popcount(conds & umask);
			end
			EV_DUAL_UOP: begin
				conds[0] = events.dual_microop_decodes;
				raw = popcount(conds & umask);
			end
			EV_LOOP_OVF: begin
				conds[0] = events.loop_stream_overflow;
				raw = popcount(conds & umask);
			end
			EV_L2_REQUEST: begin
				conds = events.l2_request;
				conds[0] = events.l2_request[0] & ~events.l2_load_rejected;
				raw = popcount(conds & umask);
			end
			EV_L2_DATA: begin
				conds = {1'b0, pf_onehot[6:4], events.demand_state};
				raw = popcount(conds & umask);
			end
			default: begin
				raw = '0;
			end
		endcase
	end

	perf_count_qualifier u_qual (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.raw(raw),
		.cmask(cmask),
		.invert(invert),
		.edge_only(edge_only),
		.inc(inc)
	);

	// ==================================================
	// Bus slave: one wait cycle on every access
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~st.ack;
	assign take = req & st.ack;
	assign avs_readdata = st.rdata;
	assign sum = {1'b0, st.count} + {{(CNT_W+1-RAW_W){1'b0}}, inc};

	always_comb begin
		next_st = st;
		next_st.ack = req & ~st.ack;
		if (req && !st.ack && avs_read) begin
			case (avs_address)
				OFS_CTRL: next_st.rdata = st.ctrl;
				OFS_COUNT: next_st.rdata = 32'(st.count);
				OFS_LAT: next_st.rdata = st.lat;
				OFS_STATUS: begin
					next_st.rdata = '0;
					next_st.rdata[STAT_OVF_BIT] = st.overflow;
					next_st.rdata[STAT_EN_BIT] = enable;
				end
				default: next_st.rdata = 32'h00000000;
			endcase
		end
		// Counting before software writes, so a write lands last
		if (enable) begin
			next_st.count = sum[CNT_W-1:0];
		end
		if (take && avs_write) begin
			case (avs_address)
				OFS_CTRL: begin
					next_st.ctrl = merge(st.ctrl, avs_writedata, avs_byteenable, CTRL_WMASK);
				end
				OFS_COUNT: begin
					next_st.count = CNT_W'(merge(32'(st.count), avs_writedata,
						avs_byteenable, 32'hFFFFFFFF));
				end
				OFS_LAT: begin
					next_st.lat = merge(st.lat, avs_writedata, avs_byteenable, LAT_WMASK);
				end
				OFS_STATUS: begin
					if (avs_byteenable[0] && avs_writedata[STAT_OVF_BIT]) begin
						next_st.overflow = 1'b0;
					end
				end
				default: begin
					next_st.overflow = next_st.overflow;
				end
			endcase
		end
		// Wrap sets the flag after any clear in the same cycle
		if (enable && sum[CNT_W]) begin
			next_st.overflow = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			st.ctrl <= CTRL_RST;
			st.count <= CNT_W'(COUNT_RST);
			st.lat <= LAT_RST;
			st.overflow <= 1'b0;
			st.ack <= 1'b0;
			st.rdata <= '0;
		end else begin
			st <= next_st;
		end
	end

	// ==================================================
	// Checks
	sequence count_write_s;
		take && avs_write && avs_address == OFS_COUNT && avs_byteenable == 4'hF;
	endsequence

	bus_one_wait_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(req && avs_waitrequest) |=> (!avs_waitrequest || !req))
		else $error("waitrequest held longer than one cycle");
	count_adds_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(enable && !(take && avs_write)) |=> count_value == CNT_W'($past(sum)))
		else $error("counter did not add this cycle's increment");
	count_load_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		count_write_s |=> count_value == CNT_W'($past(avs_writedata)))
		else $error("software write to the counter lost");
	load_count_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_MEM_RETIRED && umask == 8'h03) |->
		raw == {3'h0, events.retired_load_instr} + {3'h0, events.retired_store_instr})
		else $error("retired load and store count wrong");
	lat_gate_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_MEM_RETIRED && umask == 8'h10 && !st.lat[LAT_EN_BIT]) |-> raw == '0)
		else $error("latency class counted with facility off");
	store_fault_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_STORE_XMISS && events.store_faulted) |-> raw == '0)
		else $error("faulted store counted as translation miss");
	issue_sum_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_UOP_ISSUE && umask == 8'h01) |-> raw == {1'b0, events.issued_uops})
		else $error("issued micro-op sum wrong");
	mul_excl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_ARITH && umask == 8'h02 && events.mul_in_dot_or_sad) |-> raw == '0)
		else $error("excluded multiply counted");
	l2_miss_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_L2_REQUEST && umask == 8'hAA) |->
		raw == popcount(events.l2_request & 8'hAA))
		else $error("all-miss class wrong");
	pf_owner_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_L2_DATA && umask == 8'h20 && events.pf_ownership
		&& events.pf_state == LINE_S) |-> raw == '0)
		else $error("ownership prefetch counted as shared hit");
	ovf_sticky_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(enable && sum[CNT_W]) |=> st.overflow)
		else $error("wrap did not set overflow");
	lat_strict_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_MEM_RETIRED && umask == 8'h10
		&& events.load_lat <= st.lat[LAT_THR_LSB +: 16]) |-> raw == '0)
		else $error("load at the threshold counted as above it");
	fused_sum_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_UOP_ISSUE && umask == 8'h02) |-> raw == {1'b0, events.fused_uops})
		else $error("fused micro-op sum wrong");
	iq_cycles_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(evsel == EV_IQ_CYCLES && umask == 8'h01) |->
		raw == {3'h0, (events.instr_queue_write_count != 3'h0)})
		else $error("queue write cycle not counted once");
	ovf_clear_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
		(take && avs_write && avs_address == OFS_STATUS && avs_byteenable[0]
		&& avs_writedata[STAT_OVF_BIT] && !(enable && sum[CNT_W])) |=> !st.overflow)
		else $error("overflow flag not cleared by software");

endmodule : perf_event_selector

// *** perf_event_source.sv ***
`timescale 1ns/100ps
// ==================================================
// Pipeline strobe source: background level, plus a burst of len cycles
module perf_event_source (
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [7:0] len,
	input wire perf_sel_pkg::event_in_t bg,
	input wire perf_sel_pkg::event_in_t burst,
	output perf_sel_pkg::event_in_t events,
	output logic busy
);
	import perf_sel_pkg::*;
	logic [7:0] left;
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			left <= 8'h00;
		end else if (start) begin
			left <= len;
		end else if (left != 8'h00) begin
			left <= left - 8'h01;
		end
	end
	// Strobes change only after an edge, one level per cycle
	assign events = (left != 8'h00) ? burst : bg;
	assign busy = (left != 8'h00);
endmodule : perf_event_source

// *** tb_perf_event_selector.sv ***
`timescale 1ns/100ps
module tb_perf_event_selector;
	import perf_sel_pkg::*;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	event_in_t events;
	event_in_t bg = '0;
	event_in_t burst = '0;
	event_in_t p;
	logic start = 1'b0;
	logic [7:0] len = 8'h0;
	logic busy;
	logic [31:0] count_value;
	logic [31:0] rd;
	int errors = 0;
	int samples_checked = 0;

	always #5 sys_clk = ~sys_clk;

	perf_event_selector #(.CNT_W(32)) i_perf_event_selector (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.events(events), .count_value(count_value));
	perf_event_source i_perf_event_source (.sys_clk(sys_clk), .sys_rst(sys_rst), .start(start),
		.len(len), .bg(bg), .burst(burst), .events(events), .busy(busy));

	// ==================================================
	// Reporting
	task wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : wrap_up

	task check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	// ==================================================
	// Bus access: request held until waitrequest is sampled low
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest && n < 50);
		if (avs_waitrequest !== 1'b0) begin
			errors++;
			$display("ERROR %0t: bus never answered", $time);
			wrap_up;
		end else begin
			rd = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
		end
	endtask : bus

	task rchk(input logic [3:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rchk

	// Burst of n strobe cycles; waits on the source, bounded
	task pulse(input logic [7:0] n);
		int k;
		@(posedge sys_clk);
		len <= n;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (busy && k < 300);
		if (busy !== 1'b0) begin
			errors++;
			$display("ERROR %0t: burst stuck", $time);
			wrap_up;
		end
	endtask : pulse

	// Four-cycle burst under one selection; background must add nothing
	task run(input logic [7:0] ev, input logic [7:0] mk, input logic [31:0] exp,
		input logic [7:0] cm = 8'h0, input logic iv = 1'b0, input logic eg = 1'b0);
		bus(1'b1, OFS_COUNT, 32'h0);
		bus(1'b1, OFS_CTRL, {cm, 5'h0, iv, 1'b1, eg, mk, ev});
		pulse(8'h4);
		bus(1'b1, OFS_CTRL, 32'h0);
		rchk(OFS_COUNT, exp);
		check(count_value, exp);
	endtask : run

	// ==================================================
	// Sequence
	initial begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rchk(OFS_CTRL, CTRL_RST);
		rchk(OFS_COUNT, COUNT_RST);
		rchk(OFS_LAT, LAT_RST);
		bus(1'b1, OFS_CTRL, 32'hFFFFFFFF);
		rchk(OFS_CTRL, CTRL_WMASK);
		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, 4'h2, 32'hFFFFFFFF);
		rchk(4'h2, 32'h0);
		rchk(OFS_CTRL, 32'h0);
		bus(1'b1, OFS_LAT, 32'hFFFFFFFF);
		rchk(OFS_LAT, LAT_WMASK);
		$display("test registers done");
		p = '0; p.retired_load_instr = 1'b1; p.retired_store_instr = 1'b1; burst <= p;
		run(EV_MEM_RETIRED, 8'h01, 32'h4);
		run(EV_MEM_RETIRED, 8'h02, 32'h4);
		run(EV_MEM_RETIRED, 8'h03, 32'h8);
		bus(1'b1, OFS_LAT, 32'h80000064);
		// Latency class only for retired loads; load bit itself masked off
		p = '0; p.retired_load_instr = 1'b1; p.load_lat_valid = 1'b1;
		p.load_lat = 16'h0065; burst <= p;
		run(EV_MEM_RETIRED, 8'h10, 32'h4);
		bus(1'b1, OFS_LAT, 32'h00000064);
		run(EV_MEM_RETIRED, 8'h10, 32'h0);
		bus(1'b1, OFS_LAT, 32'h80000065);
		run(EV_MEM_RETIRED, 8'h10, 32'h0);
		p = '0; p.retired_store_xlate_miss = 1'b1; burst <= p;
		run(EV_STORE_XMISS, 8'h01, 32'h4);
		p.store_faulted = 1'b1; burst <= p;
		run(EV_STORE_XMISS, 8'h01, 32'h0);
		p.store_faulted = 1'b0; p.store_prefetch = 1'b1; burst <= p;
		run(EV_STORE_XMISS, 8'h01, 32'h0);
		p = '0; p.issued_uops = 3'h3; p.fused_uops = 3'h2; burst <= p;
		run(EV_UOP_ISSUE, 8'h01, 32'hC);
		run(EV_UOP_ISSUE, 8'h02, 32'h8);
		run(EV_UOP_ISSUE, 8'h01, 32'h4, 8'h02);
		run(EV_UOP_ISSUE, 8'h01, 32'h0, 8'h04);
		// Busy background so only the idle burst cycles qualify
		p = '0; p.issued_uops = 3'h2; bg <= p; p.issued_uops = 3'h0; burst <= p;
		run(EV_UOP_ISSUE, 8'h01, 32'h4, 8'h01, 1'b1);
		bg <= '0;
		p = '0; p.divider_busy = 1'b1; p.multiply_ops = 1'b1; burst <= p;
		run(EV_ARITH, 8'h01, 32'h4);
		run(EV_ARITH, 8'h01, 32'h1, 8'h01, 1'b1, 1'b1);
		run(EV_ARITH, 8'h01, 32'h1, 8'h01, 1'b0, 1'b1);
		run(EV_ARITH, 8'h02, 32'h4);
		p.mul_in_dot_or_sad = 1'b1; burst <= p;
		run(EV_ARITH, 8'h02, 32'h0);
		p = '0; p.instr_queue_write_count = 3'h3; p.first_decoder_instrs = 1'b1;
		p.dual_microop_decodes = 1'b1; p.loop_stream_overflow = 1'b1; burst <= p;
		run(EV_IQ_WRITES, 8'h01, 32'hC);
		run(EV_IQ_CYCLES, 8'h01, 32'h4);
		run(EV_FIRST_DECODER, 8'h01, 32'h4);
		run(EV_DUAL_UOP, 8'h01, 32'h4);
		run(EV_LOOP_OVF, 8'h01, 32'h4);
		$display("test front end done");
		p = '0; p.load_source = 8'hBA; p.float_class = 8'hFF; p.wide_int_class = 7'h7F;
		p.load_dispatch = 3'h7; p.l2_request = 8'hFF; burst <= p;
		for (int i = 0; i < 8; i++) begin
			run(EV_LOAD_SOURCE, 8'h01 << i, p.load_source[i] ? 32'h4 : 32'h0);
			run(EV_FLOAT_OPS, 8'h01 << i, 32'h4);
			run(EV_L2_REQUEST, 8'h01 << i, 32'h4);
		end
		for (int i = 0; i < 7; i++) begin
			run(EV_WIDE_INT, 8'h01 << i, 32'h4);
		end
		run(EV_FLOAT_OPS, 8'hFF, 32'h20);
		run(EV_LOAD_DISPATCH, 8'h07, 32'hC);
		run(EV_L2_REQUEST, 8'hAA, 32'h10);
		run(EV_L2_REQUEST, 8'hFF, 32'h20);
		run(EV_L2_REQUEST, 8'h03, 32'h8);
		run(EV_L2_REQUEST, 8'h0C, 32'h8);
		run(EV_L2_REQUEST, 8'h30, 32'h8);
		p.l2_load_rejected = 1'b1; burst <= p;
		run(EV_L2_REQUEST, 8'h01, 32'h0);
		$display("test classes done");
		for (int i = 0; i < 4; i++) begin
			p = '0; p.demand_state = 4'h1 << i; burst <= p;
			run(EV_L2_DATA, 8'h01 << i, 32'h4);
			run(EV_L2_DATA, 8'h0F, 32'h4);
		end
		for (int i = 0; i < 3; i++) begin
			p = '0; p.pf_valid = 1'b1; p.pf_state = 2'(i); burst <= p;
			run(EV_L2_DATA, 8'h10 << i, 32'h4);
		end
		p = '0; p.pf_valid = 1'b1; p.pf_ownership = 1'b1; p.pf_state = LINE_S; burst <= p;
		run(EV_L2_DATA, 8'h10, 32'h4);
		run(EV_L2_DATA, 8'h20, 32'h0);
		// Wrap of the counter sets the sticky flag
		p = '0; p.retired_load_instr = 1'b1; burst <= p;
		bus(1'b1, OFS_CTRL, 32'h0002010B);
		rchk(OFS_STATUS, 32'h2);
		bus(1'b1, OFS_COUNT, 32'hFFFFFFFF);
		pulse(8'h1);
		bus(1'b1, OFS_CTRL, 32'h0);
		rchk(OFS_COUNT, 32'h0);
		rchk(OFS_STATUS, 32'h1);
		bus(1'b1, OFS_STATUS, 32'h1);
		rchk(OFS_STATUS, 32'h0);
		$display("test cache and wrap done");
		wrap_up;
	end
endmodule : tb_perf_event_selector
